// ===== nvcm_pkg.sv
package nvcm_pkg;

    // ==================================================
    // Address map
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] BRIDGE_A_BASE = 32'h4000_0000;
    localparam logic [31:0] BRIDGE_B_BASE = 32'h4100_0000;
    localparam logic [31:0] BRIDGE_C_BASE = 32'h4200_0000;
    localparam logic [31:0] BRIDGE_SIZE = 32'h0001_0000;
    localparam logic [31:0] FLASH_SIZE = 32'h0004_0000;
    localparam logic [31:0] SRAM_SIZE = 32'h0000_8000;

    // ==================================================
    // Non-volatile space offsets
    localparam logic [31:0] USER_ROW_ADDR = 32'h0080_4000;
    localparam logic [31:0] CAL_AREA_ADDR = 32'h0080_6020;
    localparam logic [31:0] SERIAL0_ADDR = 32'h0080_a00c;
    localparam logic [31:0] SERIAL1_ADDR = 32'h0080_a040;
    localparam logic [31:0] SERIAL2_ADDR = 32'h0080_a044;
    localparam logic [31:0] SERIAL3_ADDR = 32'h0080_a048;
    localparam logic [31:0] NVM_NVM_PARAMETER_REGISTER_ADDR = 32'h4100_4008;

    // ==================================================
    // Flash geometry
    localparam logic [15:0] PAGE_COUNT = 16'h1000;
    localparam logic [2:0] PAGE_SIZE_CODE = 3'h0;
    localparam logic [2:0] PAGES_PER_ROW = 3'h4;
    localparam int NVM_PARAMETER_REGISTER_PSZ_LSB = 16;

    // ==================================================
    // User row field positions and erased defaults
    localparam int BOOT_PROTECT_SIZE_LSB = 0;
    localparam int EEPROM_LSB = 4;
    localparam int BOD_LEVEL_LSB = 8;
    localparam int BOD_EN_BIT = 14;
    localparam int BOD_ACT_LSB = 15;
    localparam int WD_EN_BIT = 25;
    localparam int WD_AON_BIT = 26;
    localparam int WD_PER_LSB = 27;
    localparam int WD_WIN_LSB = 31;
    localparam int WD_EWO_LSB = 35;
    localparam int WD_WEN_BIT = 39;
    localparam int BOD_HYST_BIT = 40;
    localparam int LOCK_LSB = 48;
    localparam logic [2:0] BOOT_PROTECT_SIZE_DEF = 3'h7;
    localparam logic [2:0] BOOT_PROTECT_SIZE_DEF_WL = 3'h3;
    localparam logic [2:0] EEPROM_DEF = 3'h7;
    localparam logic [5:0] BOD_LEVEL_DEF = 6'h07;
    localparam logic [1:0] BOD_ACT_DEF = 2'h1;
    localparam logic [3:0] WD_PER_DEF = 4'hb;
    localparam logic [3:0] WD_WIN_DEF = 4'h5;
    localparam logic [3:0] WD_EWO_DEF = 4'hb;
    localparam logic [15:0] LOCK_DEF = 16'hffff;

    // ==================================================
    // Calibration field positions
    localparam int CAL_LIN_LSB = 27;
    localparam int CAL_BIAS_LSB = 35;
    localparam int CAL_OSC_LSB = 38;
    localparam int CAL_COARSE_LSB = 58;
    localparam int CAL_FINE_LSB = 64;

    // Decoded region of an access
    typedef enum logic [3:0] {
        NVCM_RG_NONE = 4'h0,
        NVCM_RG_FLASH = 4'h1,
        NVCM_RG_SRAM = 4'h2,
        NVCM_RG_BRA = 4'h3,
        NVCM_RG_BRB = 4'h4,
        NVCM_RG_BRC = 4'h5,
        NVCM_RG_NVM = 4'h6
    } nvcm_region_e;

    // Power-on configuration handed to consumers
    typedef struct packed {
        logic [2:0] boot_protect_size;
        logic [2:0] eeprom_size;
        logic [5:0] bod_level;
        logic bod_enable;
        logic [1:0] bod_action;
        logic bod_hyst;
        logic wd_enable;
        logic wd_always_on;
        logic [3:0] wd_period;
        logic [3:0] wd_window;
        logic [3:0] early_warning_offset;
        logic wd_window_en;
        logic [15:0] region_lock;
    } nvcm_cfg_s;

endpackage

// ===== nvcm_top.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// R1: Region map is fixed; nothing ever remaps, also not during boot.
// R2: Flash at 0, SRAM at 0x20000000, three 64 KB bridges at 0x40/41/42000000.
// R3: Flash in 64-byte pages, four per row; count and size readable in parameters.
// R4: Calibration row values load into destination registers at startup automatically.
// R5: At power-on the first two user row words are read and applied.
// R6: User row readable from byte address 0x804000.
// R7: New user row values act only after the next reset reloads them.
// R8: Bits 2:0 boot protection size, default 7, or 3 on small package.
// R9: Bits 6:4 emulated EEPROM size, default 7.
// R10: Brownout level 13:8, enable 14, action 16:15, hysteresis 40 set at power-on.
// R11: Watchdog enable 25, always-on 26, period 30:27 set at power-on.
// R12: Window timeout 34:31, early warning 38:35, window enable 39 at power-on.
// R13: Bits 63:48 are region lock bits applied at power-on.
// R14: Software rewriting the user row preserves reserved bits and ignores them.
// R15: Calibration area readable at 0x806020; writes are refused.
// R16: Software copies converter and oscillator trims from calibration fields. Here they load automatically at startup.
// R17: Software copies loop coarse and fine trims; invalid on early dies. Here they load automatically at startup.
// R18: 128-bit serial number in four read-only words at fixed addresses.
// R19: Consumers use all four serial words together for uniqueness.
// R20: Accesses outside all regions answer with an error.
module nvcm_top #(
    parameter logic [63:0] USER_ROW_INIT = 64'hffff_ffff_ffff_ffff, // Erased user row content
    parameter logic [127:0] CAL_INIT = 128'h0, // Factory calibration (arbitrary)
    parameter logic [127:0] SERIAL_INIT = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978, // Arbitrary
    parameter bit WAFER_PKG = 1'b0 // Small package variant
) (
    input wire logic clk_i, // System clock 125 MHz
    input wire logic srst_i, // Synchronous reset, high
    input wire logic ce_i, // Clock enable
    input wire logic [31:0] addr_i, // Byte address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic row_wr_i, // Programming path: write a user row word
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    output logic rvalid_o, // Read data valid
    output logic err_o, // Error answer, cycle after strobe
    output nvcm_pkg::nvcm_region_e region_o, // Region of last access
    output logic [4:0] sel_o, // One-hot slave select of last access
    output logic load_done_o, // Power-on load complete
    output nvcm_pkg::nvcm_cfg_s cfg_o, // Applied configuration
    output logic [7:0] adc_linearity_o, // Converter calibration
    output logic [2:0] converter_bias_trim_o, // Converter bias
    output logic [6:0] internal_32k_oscillator_trim_o, // Oscillator trim
    output logic [5:0] loop_coarse_o, // Loop coarse trim
    output logic [9:0] loop_fine_o // Loop fine trim
);
    import nvcm_pkg::*;

    // ==================================================
    // Decode
    // Fixed comparisons only: no remap state exists, so boot cannot move a region.
    function automatic nvcm_region_e decode(input logic [31:0] a);
        nvcm_region_e r;
        r = NVCM_RG_NONE;
        if (a >= FLASH_BASE && a < FLASH_BASE + FLASH_SIZE) begin // [R1] [R2]
            r = NVCM_RG_FLASH;
        end else if (a == USER_ROW_ADDR || a == USER_ROW_ADDR + 32'h4 ||
                     (a >= CAL_AREA_ADDR && a < CAL_AREA_ADDR + 32'h10) ||
                     a == SERIAL0_ADDR || a == SERIAL1_ADDR || a == SERIAL2_ADDR || a == SERIAL3_ADDR) begin
            r = NVCM_RG_NVM;
        end else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_SIZE) begin // [R2]
            r = NVCM_RG_SRAM;
        end else if (a >= BRIDGE_A_BASE && a < BRIDGE_A_BASE + BRIDGE_SIZE) begin // [R2]
            r = NVCM_RG_BRA;
        end else if (a >= BRIDGE_B_BASE && a < BRIDGE_B_BASE + BRIDGE_SIZE) begin // [R2]
            r = NVCM_RG_BRB;
        end else if (a >= BRIDGE_C_BASE && a < BRIDGE_C_BASE + BRIDGE_SIZE) begin // [R2]
            r = NVCM_RG_BRC;
        end
        return r;
    endfunction

    // ==================================================
    // Storage: non-volatile user row survives reset
    logic [63:0] user_row = USER_ROW_INIT;
    logic [63:0] next_user_row;
    nvcm_region_e acc_rg;
    logic load_busy;

    assign acc_rg = decode(addr_i);

    // Programming path only touches the stored row, never the applied copy [R7]
    always_comb begin
        next_user_row = user_row;
        if (row_wr_i && wr_i && addr_i == USER_ROW_ADDR) begin
            next_user_row[31:0] = wdata_i;
        end else if (row_wr_i && wr_i && addr_i == USER_ROW_ADDR + 32'h4) begin
            next_user_row[63:32] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            user_row <= next_user_row;
        end
    end

    // ==================================================
    // Power-on load: two word reads, then apply
    typedef enum logic [2:0] {
        NVCM_LD_W0 = 3'b001,
        NVCM_LD_W1 = 3'b010,
        NVCM_LD_DONE = 3'b100
    } nvcm_ld_e;
    nvcm_ld_e ld_state;
    logic [63:0] load_buf;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ld_state <= NVCM_LD_W0;
            load_buf <= 64'h0;
        end else if (ce_i) begin
            case (ld_state)
                NVCM_LD_W0: begin
                    load_buf[31:0] <= user_row[31:0]; // [R5]
                    ld_state <= NVCM_LD_W1;
                end
                NVCM_LD_W1: begin
                    load_buf[63:32] <= user_row[63:32]; // [R5]
                    ld_state <= NVCM_LD_DONE;
                end
                NVCM_LD_DONE: begin
                    ld_state <= NVCM_LD_DONE;
                end
                default: begin
                    ld_state <= NVCM_LD_W0;
                end
            endcase
        end
    end

    assign load_busy = (ld_state != NVCM_LD_DONE);

    // ==================================================
    // Applied configuration: defaults in reset, row values once loaded
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_o.boot_protect_size <= WAFER_PKG ? BOOT_PROTECT_SIZE_DEF_WL : BOOT_PROTECT_SIZE_DEF; // [R8]
            cfg_o.eeprom_size <= EEPROM_DEF;
            cfg_o.bod_level <= BOD_LEVEL_DEF;
            cfg_o.bod_enable <= 1'b1;
            cfg_o.bod_action <= BOD_ACT_DEF;
            cfg_o.bod_hyst <= 1'b1;
            cfg_o.wd_enable <= 1'b0;
            cfg_o.wd_always_on <= 1'b0;
            cfg_o.wd_period <= WD_PER_DEF;
            cfg_o.wd_window <= WD_WIN_DEF;
            cfg_o.early_warning_offset <= WD_EWO_DEF;
            cfg_o.wd_window_en <= 1'b0;
            cfg_o.region_lock <= LOCK_DEF;
            load_done_o <= 1'b0;
        end else if (ce_i && ld_state == NVCM_LD_DONE && !load_done_o) begin
            cfg_o.boot_protect_size <= load_buf[BOOT_PROTECT_SIZE_LSB +: 3]; // [R8]
            cfg_o.eeprom_size <= load_buf[EEPROM_LSB +: 3]; // [R9]
            cfg_o.bod_level <= load_buf[BOD_LEVEL_LSB +: 6]; // [R10]
            cfg_o.bod_enable <= load_buf[BOD_EN_BIT]; // [R10]
            cfg_o.bod_action <= load_buf[BOD_ACT_LSB +: 2]; // [R10]
            cfg_o.bod_hyst <= load_buf[BOD_HYST_BIT]; // [R10]
            cfg_o.wd_enable <= load_buf[WD_EN_BIT]; // [R11]
            cfg_o.wd_always_on <= load_buf[WD_AON_BIT]; // [R11]
            cfg_o.wd_period <= load_buf[WD_PER_LSB +: 4]; // [R11]
            cfg_o.wd_window <= load_buf[WD_WIN_LSB +: 4]; // [R12]
            cfg_o.early_warning_offset <= load_buf[WD_EWO_LSB +: 4]; // [R12]
            cfg_o.wd_window_en <= load_buf[WD_WEN_BIT]; // [R12]
            cfg_o.region_lock <= load_buf[LOCK_LSB +: 16]; // [R13]
            load_done_o <= 1'b1;
        end
    end

    // ==================================================
    // Automatic calibration row into destination registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            adc_linearity_o <= 8'h0;
            converter_bias_trim_o <= 3'h0;
            internal_32k_oscillator_trim_o <= 7'h0;
            loop_coarse_o <= 6'h0;
            loop_fine_o <= 10'h0;
        end else if (ce_i && ld_state == NVCM_LD_W0) begin
            adc_linearity_o <= CAL_INIT[CAL_LIN_LSB +: 8]; // [R4]
            converter_bias_trim_o <= CAL_INIT[CAL_BIAS_LSB +: 3]; // [R4]
            internal_32k_oscillator_trim_o <= CAL_INIT[CAL_OSC_LSB +: 7]; // [R4]
            loop_coarse_o <= CAL_INIT[CAL_COARSE_LSB +: 6]; // [R4] [R17]
            loop_fine_o <= CAL_INIT[CAL_FINE_LSB +: 10]; // [R4] [R17]
        end
    end

    // ==================================================
    // Register read path
    // Other regions belong to other slaves; here they read as zero without error, except the parameter register in bridge B.
    logic [31:0] next_rdata;
    logic next_err;

    always_comb begin
        next_rdata = 32'h0;
        next_err = 1'b0;
        case (addr_i)
            USER_ROW_ADDR: next_rdata = user_row[31:0]; // [R6]
            USER_ROW_ADDR + 32'h4: next_rdata = user_row[63:32]; // [R6]
            CAL_AREA_ADDR: next_rdata = CAL_INIT[31:0]; // [R15]
            CAL_AREA_ADDR + 32'h4: next_rdata = CAL_INIT[63:32]; // [R15]
            CAL_AREA_ADDR + 32'h8: next_rdata = CAL_INIT[95:64]; // [R15]
            CAL_AREA_ADDR + 32'hc: next_rdata = CAL_INIT[127:96]; // [R15]
            SERIAL0_ADDR: next_rdata = SERIAL_INIT[31:0]; // [R18]
            SERIAL1_ADDR: next_rdata = SERIAL_INIT[63:32]; // [R18]
            SERIAL2_ADDR: next_rdata = SERIAL_INIT[95:64]; // [R18]
            SERIAL3_ADDR: next_rdata = SERIAL_INIT[127:96]; // [R18]
            NVM_NVM_PARAMETER_REGISTER_ADDR: next_rdata = {13'h0, PAGE_SIZE_CODE, PAGE_COUNT}; // [R3]
            default: next_rdata = 32'h0;
        endcase
        if (acc_rg == NVCM_RG_NONE) begin
            next_err = 1'b1; // [R20]
        end
        // Calibration and serial words are read-only: writes are refused [R15]
        if (wr_i && acc_rg == NVCM_RG_NVM && !(row_wr_i && (addr_i == USER_ROW_ADDR ||
            addr_i == USER_ROW_ADDR + 32'h4))) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0;
            rvalid_o <= 1'b0;
            err_o <= 1'b0;
        end else if (ce_i) begin
            rvalid_o <= rd_i && acc_rg != NVCM_RG_NONE;
            rdata_o <= (rd_i && acc_rg != NVCM_RG_NONE) ? next_rdata : 32'h0;
            err_o <= (rd_i || wr_i) && next_err; // [R20]
        end
    end

    // ==================================================
    // Slave select of last access
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            region_o <= NVCM_RG_NONE;
            sel_o <= 5'h0;
        end else if (ce_i && (rd_i || wr_i)) begin
            region_o <= acc_rg; // [R1]
            case (acc_rg)
                NVCM_RG_FLASH: sel_o <= 5'h01;
                NVCM_RG_NVM: sel_o <= 5'h01;
                NVCM_RG_BRA: sel_o <= 5'h02;
                NVCM_RG_BRB: sel_o <= 5'h04;
                NVCM_RG_BRC: sel_o <= 5'h08;
                NVCM_RG_SRAM: sel_o <= 5'h10;
                default: sel_o <= 5'h00;
            endcase
        end
    end

    // ==================================================
    // Checks
    sequence s_load_seq;
        ld_state == NVCM_LD_W0 ##1 ld_state == NVCM_LD_W1 ##1 ld_state == NVCM_LD_DONE;
    endsequence

    load_order_a: assert property (@(posedge clk_i) disable iff (!ce_i) // [R5]
        $fell(srst_i) |-> s_load_seq) else $error("load sequence broken");
    load_done_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R5]
        $rose(load_done_o) |-> cfg_o.region_lock == $past(load_buf[LOCK_LSB +: 16])) else $error("lock not applied");
    cfg_hold_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R7]
        load_done_o && $past(load_done_o) |-> $stable(cfg_o)) else $error("config changed without reset");
    boot_def_a: assert property (@(posedge clk_i) // [R8]
        $past(srst_i) |-> cfg_o.boot_protect_size == (WAFER_PKG ? BOOT_PROTECT_SIZE_DEF_WL : BOOT_PROTECT_SIZE_DEF))
        else $error("boot default wrong");
    unmapped_err_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R20]
        (rd_i && acc_rg == NVCM_RG_NONE) |=> err_o && !rvalid_o) else $error("no error on unmapped");
    serial_rd_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R18]
        (rd_i && addr_i == SERIAL3_ADDR) |=> rdata_o == SERIAL_INIT[127:96]) else $error("serial word wrong");
    cal_wr_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R15]
        (wr_i && addr_i == CAL_AREA_ADDR) |=> err_o) else $error("calibration write accepted");
    bridge_sel_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R2]
        (rd_i && addr_i == BRIDGE_B_BASE) |=> sel_o == 5'h04) else $error("bridge select wrong");
    nvm_parameter_register_rd_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R3]
        (rd_i && addr_i == NVM_NVM_PARAMETER_REGISTER_ADDR) |=> rdata_o[15:0] == PAGE_COUNT) else $error("page count wrong");
    // Configuration must not be reported as applied while the row is still being fetched
    load_busy_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R5]
        load_busy |-> !load_done_o) else $error("load done while busy");
    row_rd_a: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i) // [R6]
        (rd_i && !row_wr_i && addr_i == USER_ROW_ADDR) |=> rdata_o == $past(user_row[31:0]))
        else $error("user row read wrong");

endmodule

// ===== nvcm_bus_model.sv
`timescale 1ns/10ps
// ==================================================
// Bus matrix side: one master issuing single reads and writes
module nvcm_bus_model (
    input wire logic clk_i, // System clock
    input wire logic [31:0] rdata_i, // Read data
    input wire logic rvalid_i, // Read data valid
    input wire logic err_i, // Error answer
    output logic [31:0] addr_o, // Byte address
    output logic [31:0] wdata_o, // Write data
    output logic wr_o, // Write strobe
    output logic rd_o, // Read strobe
    output logic row_wr_o // Programming path select
);
    // Idle bus at time zero
    initial begin
        addr_o = 32'h0;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        row_wr_o = 1'b0;
    end

    // One strobe cycle; address and data are scrambled once released so stale values never help
    task automatic access(input logic w, input logic row, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic v, output logic e);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        row_wr_o <= row;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        row_wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        @(posedge clk_i);
        q = rdata_i;
        v = rvalid_i;
        e = err_i;
    endtask

    // Rewrite one user row word, keeping the reserved bits exactly as read back
    task automatic row_update(input logic [31:0] a, input logic [31:0] val, input logic [31:0] rsv,
                              output logic [31:0] merged, output logic e);
        logic [31:0] old;
        logic v;
        access(1'b0, 1'b0, a, 32'h0, old, v, e);
        merged = (old & rsv) | (val & ~rsv);
        access(1'b1, 1'b1, a, merged, old, v, e);
    endtask
endmodule

// ===== tb_nvcm_top.sv
`timescale 1ns/10ps
module tb_nvcm_top;
    import nvcm_pkg::*;
    // ==================================================
    // Stimulus values; calibration and serial contents are arbitrary
    localparam logic [63:0] ROW = 64'h7a5c_0123_4567_89ab;
    localparam logic [127:0] CAL = 128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978;
    localparam logic [127:0] SER = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    localparam nvcm_cfg_s DEF = {3'h7, 3'h7, 6'h07, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 4'hb, 4'h5, 4'hb, 1'b0, 16'hffff};
    logic clk_i;
    logic srst_i;
    logic [31:0] addr, wdata, rdata;
    logic wr, rd, row_wr, rvalid, err, load_done;
    nvcm_region_e region;
    logic [4:0] sel;
    nvcm_cfg_s cfg;
    logic [7:0] lin;
    logic [2:0] bias;
    logic [6:0] osc;
    logic [5:0] coarse;
    logic [9:0] fine;
    int err_count = 0;
    int checked = 0;

    nvcm_top #(.USER_ROW_INIT(ROW), .CAL_INIT(CAL), .SERIAL_INIT(SER), .WAFER_PKG(1'b0)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .row_wr_i(row_wr), .rdata_o(rdata), .rvalid_o(rvalid), .err_o(err), .region_o(region), .sel_o(sel),
        .load_done_o(load_done), .cfg_o(cfg), .adc_linearity_o(lin), .converter_bias_trim_o(bias),
        .internal_32k_oscillator_trim_o(osc), .loop_coarse_o(coarse), .loop_fine_o(fine));
    nvcm_bus_model i_bm (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .err_i(err), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .row_wr_o(row_wr));

    // ==================================================
    // Clock at 125 MHz, and a hard stop if anything hangs
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end

    // ==================================================
    // Shared helpers
    function automatic nvcm_cfg_s cfg_of(input logic [63:0] r);
        return {r[2:0], r[6:4], r[13:8], r[14], r[16:15], r[40], r[25], r[26], r[30:27], r[34:31],
                r[38:35], r[39], r[63:48]};
    endfunction
    task automatic check(input string n, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Read expecting data, no error, and the given region
    task automatic rd_chk(input string n, input logic [31:0] a, input logic [31:0] exp, input nvcm_region_e rg);
        logic [31:0] q;
        logic v, e;
        i_bm.access(1'b0, 1'b0, a, 32'h0, q, v, e);
        check({n, "_v"}, {v, e}, 2'b10);
        check(n, q, exp);
        check({n, "_rg"}, region, rg);
    endtask
    // Access expected to be refused with an error and no data
    task automatic refused(input string n, input logic w, input logic [31:0] a);
        logic [31:0] q;
        logic v, e;
        i_bm.access(w, 1'b0, a, 32'h5a5a_a5a5, q, v, e);
        check(n, {v, e}, 2'b01);
    endtask

    // ==================================================
    // Scenarios
    // Reset shows erased defaults, release loads the row within a few cycles
    task automatic t_reset(input logic [63:0] row);
        int n;
        srst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        check("cfg_reset", cfg, DEF);
        check("load_reset", load_done, 1'b0);
        srst_i <= 1'b0;
        n = 0;
        while (load_done !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 10) begin
            err_count++;
            conclude();
        end
        check("cfg_load", cfg, cfg_of(row));
    endtask
    // Calibration row values reach their destinations with no bus traffic
    task automatic t_cal_load;
        check("lin", lin, CAL[34:27]);
        check("bias", bias, CAL[37:35]);
        check("osc", osc, CAL[44:38]);
        check("coarse", coarse, CAL[63:58]);
        check("fine", fine, CAL[73:64]);
    endtask
    // All four serial words are read and judged as one value, never a part alone
    task automatic t_serial;
        logic [127:0] s;
        logic v, e;
        logic [31:0] a [4] = '{32'h0080_a00c, 32'h0080_a040, 32'h0080_a044, 32'h0080_a048};
        for (int i = 0; i < 4; i++) begin
            i_bm.access(1'b0, 1'b0, a[i], 32'h0, s[32 * i +: 32], v, e);
        end
        check("ser_all", s, SER);
    endtask
    // Fixed map: every window, its select line, the edge just past bridge A, and a high gap
    task automatic t_map;
        logic [31:0] ma [5] = '{32'h0, 32'h2000_0000, 32'h4000_0000, 32'h4100_0000, 32'h4200_fffc};
        nvcm_region_e mr [5] = '{NVCM_RG_FLASH, NVCM_RG_SRAM, NVCM_RG_BRA, NVCM_RG_BRB, NVCM_RG_BRC};
        logic [4:0] ms [5] = '{5'h01, 5'h10, 5'h02, 5'h04, 5'h08};
        for (int i = 0; i < 5; i++) begin
            rd_chk("map", ma[i], 32'h0, mr[i]);
            check("sel", sel, ms[i]);
        end
        refused("gap_bridge", 1'b0, 32'h4001_0000);
        refused("gap_high", 1'b0, 32'h6000_0000);
    endtask
    // Non-volatile space reads: user row, calibration, serial, flash geometry
    task automatic t_nvm(input logic [63:0] row);
        for (int i = 0; i < 2; i++) begin
            rd_chk("row", 32'h0080_4000 + 4 * i, row[32 * i +: 32], NVCM_RG_NVM);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk("cal", 32'h0080_6020 + 4 * i, CAL[32 * i +: 32], NVCM_RG_NVM);
        end
        rd_chk("ser0", 32'h0080_a00c, SER[31:0], NVCM_RG_NVM);
        check("ser_sel", sel, 5'h01);
        for (int i = 1; i < 4; i++) begin
            rd_chk("ser", 32'h0080_a040 + 4 * (i - 1), SER[32 * i +: 32], NVCM_RG_NVM);
        end
        rd_chk("nvm_parameter_register", 32'h4100_4008, 32'h0000_1000, NVCM_RG_BRB);
    endtask
    // Read-only places refuse writes and keep their content
    task automatic t_refuse;
        refused("wr_cal", 1'b1, 32'h0080_6020);
        refused("wr_ser", 1'b1, 32'h0080_a044);
        refused("wr_row_plain", 1'b1, 32'h0080_4000);
        rd_chk("cal_kept", 32'h0080_6020, CAL[31:0], NVCM_RG_NVM);
        rd_chk("ser_kept", 32'h0080_a044, SER[95:64], NVCM_RG_NVM);
    endtask
    // A programmed row word is readable at once but applied only after reset
    task automatic t_row_write;
        logic [31:0] merged;
        logic e;
        logic [63:0] nrow;
        i_bm.row_update(32'h0080_4000, 32'h0012_3452, 32'h01fe_0088, merged, e);
        check("row_wr_err", e, 1'b0);
        nrow = {ROW[63:32], merged};
        rd_chk("row_new", 32'h0080_4000, merged, NVCM_RG_NVM);
        check("cfg_held", cfg, cfg_of(ROW));
        t_reset(nrow);
        t_map();
        t_nvm(nrow);
    endtask

    // ==================================================
    // Main sequence
    initial begin
        srst_i = 1'b1;
        t_reset(ROW);
        t_cal_load();
        t_map();
        t_nvm(ROW);
        t_refuse();
        t_serial();
        t_row_write();
        conclude();
    end
endmodule
